// ---- afrc_host.sv ----
// Host controller that drives a 4096 x 9 strobe-timed FIFO through its pins.
`timescale 1ns/100ps

// Notes on behaviour
// - rewind pulse with write and read high
// - no second write wrap during replays
// - standalone holds chain input low
// - width expansion uses composite flags
// - cascade chain closes into ring; the host drives the chain input high in cascade instead
// - exactly one first-load device, low
// - composite cascade flags by OR gate
// - bidirectional uses two opposed buffers
module afrc_host import afrc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // Buffer device pins
    output afrc_pins_s fifo_pins,
    input wire afrc_flags_s fifo_flags
);

    afrc_state_e state_r;
    afrc_op_e op_r;
    logic [2:0] cnt_r;
    logic [1:0] ctrl_r;
    logic [8:0] wdata_r;
    logic [8:0] rdata_r;
    logic cascade_r;
    logic refused_r;
    logic rewound_r;
    logic [12:0] words_r;
    logic wait_r;
    logic [31:0] readdata_r;
    logic init_n_r;
    logic wr_n_r;
    logic rd_n_r;
    logic flrt_n_r;
    logic chain_in_n_r;

    // Bus decode.
    wire req = avs_read | avs_write;
    wire hit_cmd = avs_address == REG_CMD;
    wire hit_wdata = avs_address == REG_WDATA;
    wire busy = state_r != AFRC_IDLE;
    wire stall = avs_write & busy & (hit_cmd | hit_wdata);
    wire commit = req & ~wait_r;
    wire wr_commit = commit & avs_write;
    wire cmd_go = wr_commit & hit_cmd;

    wire casc_full_n = |fifo_flags.full_flag_n;
    wire casc_empty_n = |fifo_flags.empty_flag_n;
    wire wide_full_n = &fifo_flags.full_flag_n;
    wire wide_empty_n = &fifo_flags.empty_flag_n;
    wire comp_full_n = cascade_r ? casc_full_n : wide_full_n;
    wire comp_empty_n = cascade_r ? casc_empty_n : wide_empty_n;
    wire half_n = cascade_r | fifo_flags.chain_out_or_half_flag;

    // Command selection, reset first, then rewind, write, read.
    wire do_init = avs_writedata[CMD_INIT];
    wire do_rew = ~do_init & avs_writedata[CMD_REWIND];
    wire do_wr = ~do_init & ~do_rew & avs_writedata[CMD_WRITE];
    wire do_rd = ~do_init & ~do_rew & ~do_wr & avs_writedata[CMD_READ];
    wire bad_rew = do_rew & cascade_r;
    wire wrap_hit = rewound_r & (words_r == DEPTH_WORDS);
    wire bad_wr = do_wr & (~comp_full_n | wrap_hit);
    wire bad_rd = do_rd & ~comp_empty_n;
    wire refuse = cmd_go & (bad_rew | bad_wr | bad_rd);
    wire start = cmd_go & (do_init | (do_rew & ~bad_rew) | (do_wr & ~bad_wr) | (do_rd & ~bad_rd));
    wire pulse_end = (state_r == AFRC_PULSE) & (cnt_r == PULSE_CYC - 3'h1);
    wire recov_end = (state_r == AFRC_RECOV) & (cnt_r == RECOV_CYC - 3'h1);

    wire [31:0] status_word = {25'h0, rewound_r, refused_r, cascade_r, half_n,
                               comp_full_n, comp_empty_n, busy};
    wire [31:0] rd_mux =
        (avs_address == REG_CTRL) ? {30'h0, ctrl_r} :
        (avs_address == REG_RDATA) ? {23'h0, rdata_r} :
        (avs_address == REG_STATUS) ? status_word :
        (avs_address == REG_COUNT) ? {19'h0, words_r} : 32'h0;

    // Bus handshake: one wait cycle, longer for CMD or WDATA writes while a strobe is in flight.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            wait_r <= 1'b1;
            readdata_r <= 32'h0;
        end else if (req & wait_r & ~stall) begin
            wait_r <= 1'b0;
            readdata_r <= rd_mux;
        end else begin
            wait_r <= 1'b1;
        end
    end

    // Software registers.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_r <= CTRL_RST;
            wdata_r <= WDATA_RST;
        end else if (wr_commit & (avs_address == REG_CTRL)) begin
            ctrl_r <= avs_writedata[1:0];
        end else if (wr_commit & hit_wdata) begin
            wdata_r <= avs_writedata[8:0];
        end
    end

    // Refusal flag: a new refusal wins over a clear.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            refused_r <= 1'b0;
        end else if (refuse) begin
            refused_r <= 1'b1;
        end else if (wr_commit & (avs_address == REG_STATUS) & avs_writedata[ST_REFUSED]) begin
            refused_r <= 1'b0;
        end
    end

    // Replay bookkeeping: writes since reset and whether a rewind happened.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            words_r <= 13'h0;
            rewound_r <= 1'b0;
        end else if (start & do_init) begin
            words_r <= 13'h0;
            rewound_r <= 1'b0;
        end else if (start & do_wr) begin
            // count up to a full block
            if (words_r != DEPTH_WORDS) begin
                words_r <= words_r + 13'h1;
            end
        end else if (start & do_rew) begin
            rewound_r <= 1'b1;
        end
    end

    // Strobe sequencer.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_r <= AFRC_IDLE;
            op_r <= AFRC_OP_INIT;
            cnt_r <= 3'h0;
        end else begin
            case (state_r)
                AFRC_IDLE: begin
                    cnt_r <= 3'h0;
                    if (start) begin
                        state_r <= AFRC_PULSE;
                        op_r <= do_init ? AFRC_OP_INIT : do_rew ? AFRC_OP_REWIND :
                                do_wr ? AFRC_OP_WRITE : AFRC_OP_READ;
                    end
                end
                AFRC_PULSE: begin
                    cnt_r <= pulse_end ? 3'h0 : cnt_r + 3'h1;
                    if (pulse_end) begin
                        state_r <= AFRC_RECOV;
                    end
                end
                default: begin
                    cnt_r <= cnt_r + 3'h1;
                    if (recov_end) begin
                        state_r <= AFRC_IDLE;
                    end
                end
            endcase
        end
    end

    // Pin drivers; all strobes idle high.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            init_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            flrt_n_r <= 1'b1;
            chain_in_n_r <= 1'b0;
            cascade_r <= 1'b0;
        end else if (start & do_init) begin
            init_n_r <= 1'b0;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            cascade_r <= ctrl_r[CTRL_CASCADE];
            chain_in_n_r <= ctrl_r[CTRL_CASCADE];
            // only the chosen device loads first
            flrt_n_r <= ~(ctrl_r[CTRL_CASCADE] & ctrl_r[CTRL_FIRST]);
        end else if (start & do_rew) begin
            flrt_n_r <= 1'b0;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
        end else if (start & do_wr) begin
            wr_n_r <= 1'b0;
        end else if (start & do_rd) begin
            rd_n_r <= 1'b0;
        end else if (pulse_end) begin
            init_n_r <= 1'b1;
            wr_n_r <= 1'b1;
            rd_n_r <= 1'b1;
            // first-load level stays in cascade
            // Only a rewind pulse is released here; the level set at init stands.
            if (op_r == AFRC_OP_REWIND) begin
                flrt_n_r <= 1'b1;
            end
        end
    end

    // Read data is taken at the end of the read pulse, after access time.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rdata_r <= 9'h000;
        end else if (pulse_end & (op_r == AFRC_OP_READ)) begin
            rdata_r <= fifo_flags.read_word_out;
        end
    end

    assign avs_readdata = readdata_r;
    assign avs_waitrequest = wait_r;
    // strobes, mode pins and write data on one side
    assign fifo_pins = '{init_strobe_n: init_n_r, write_strobe_n: wr_n_r,
                         read_strobe_n: rd_n_r, first_load_or_rewind_n: flrt_n_r,
                         chain_token_in_n: chain_in_n_r, write_word_in: wdata_r};

endmodule : afrc_host

// ---- afrc_pkg.sv ----
// Shared constants, types and helpers for the FIFO host controller.
package afrc_pkg;

    // Clock and pin timing, slowest speed grade, in nanoseconds.
    localparam int CLK_NS = 10;
    localparam int PULSE_NS = 50;
    localparam int RECOV_NS = 15;

    // Converts a least time into whole clock cycles, at least one.
    function automatic int afrc_cycles(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : afrc_cycles

    localparam logic [2:0] PULSE_CYC = 3'(afrc_cycles(PULSE_NS));
    localparam logic [2:0] RECOV_CYC = 3'(afrc_cycles(RECOV_NS));

    // Device geometry.
    localparam int WORD_W = 9;
    localparam int NDEV = 3;
    localparam logic [12:0] DEPTH_WORDS = 13'h1000;

    // Register byte addresses.
    localparam logic [4:0] REG_CTRL = 5'h00;
    localparam logic [4:0] REG_CMD = 5'h04;
    localparam logic [4:0] REG_WDATA = 5'h08;
    localparam logic [4:0] REG_RDATA = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;
    localparam logic [4:0] REG_COUNT = 5'h14;

    // Field positions.
    localparam int CTRL_CASCADE = 0;
    localparam int CTRL_FIRST = 1;
    localparam int CMD_INIT = 0;
    localparam int CMD_WRITE = 1;
    localparam int CMD_READ = 2;
    localparam int CMD_REWIND = 3;
    localparam int ST_BUSY = 0;
    localparam int ST_EMPTY_N = 1;
    localparam int ST_FULL_N = 2;
    localparam int ST_HALF_N = 3;
    localparam int ST_CASCADE = 4;
    localparam int ST_REFUSED = 5;
    localparam int ST_REWOUND = 6;

    // Reset values.
    localparam logic [1:0] CTRL_RST = 2'h0;
    localparam logic [8:0] WDATA_RST = 9'h000;

    typedef enum logic [1:0] {AFRC_IDLE, AFRC_PULSE, AFRC_RECOV} afrc_state_e;
    typedef enum logic [1:0] {AFRC_OP_INIT, AFRC_OP_WRITE, AFRC_OP_READ, AFRC_OP_REWIND} afrc_op_e;

    // Pins driven towards the buffer devices.
    typedef struct packed {
        logic init_strobe_n;
        logic write_strobe_n;
        logic read_strobe_n;
        logic first_load_or_rewind_n;
        logic chain_token_in_n;
        logic [WORD_W-1:0] write_word_in;
    } afrc_pins_s;

    // Pins received from the buffer devices.
    typedef struct packed {
        logic [NDEV-1:0] full_flag_n;
        logic [NDEV-1:0] empty_flag_n;
        logic chain_out_or_half_flag;
        logic [WORD_W-1:0] read_word_out;
    } afrc_flags_s;

endpackage : afrc_pkg

// ---- afrc_properties.sv ----
// Checker of the FIFO host controller port behaviour.
`timescale 1ns/100ps
module afrc_properties import afrc_pkg::*; (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Register bus
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    // Device pins
    input wire afrc_pins_s fifo_pins,
    input wire afrc_flags_s fifo_flags
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    wire cas = fifo_pins.chain_token_in_n;
    wire rw_n = fifo_pins.first_load_or_rewind_n;
    wire wr_n = fifo_pins.write_strobe_n;
    wire rd_n = fifo_pins.read_strobe_n;
    wire ini_n = fifo_pins.init_strobe_n;
    wire emp_ok = cas ? |fifo_flags.empty_flag_n : &fifo_flags.empty_flag_n;
    wire ful_ok = cas ? |fifo_flags.full_flag_n : &fifo_flags.full_flag_n;
    sequence s_pulse(sig);
        !sig [*5] ##1 sig;
    endsequence
    property p_wait_one; !avs_waitrequest |=> avs_waitrequest; endproperty
    a_wait_one: assert property (p_wait_one) else $error("waitrequest low twice");
    property p_read_fast; $rose(avs_read) |=> !avs_waitrequest; endproperty
    a_read_fast: assert property (p_read_fast) else $error("read answer late");
    property p_rewind_quiet; !rw_n && !cas |-> wr_n && rd_n; endproperty
    a_rewind_quiet: assert property (p_rewind_quiet) else $error("strobe during rewind");
    property p_rewind_pulse; $fell(rw_n) && !cas |-> s_pulse(rw_n); endproperty
    a_rewind_pulse: assert property (p_rewind_pulse) else $error("rewind pulse shape");
    property p_no_rewind_cas; cas && $past(cas) && ini_n |-> $stable(rw_n); endproperty
    a_no_rewind_cas: assert property (p_no_rewind_cas) else $error("rewind in cascade");
    property p_init_quiet; !ini_n |-> wr_n && rd_n; endproperty
    a_init_quiet: assert property (p_init_quiet) else $error("strobe during init");
    property p_init_mode; !ini_n && !$past(ini_n) |-> $stable(cas) && $stable(rw_n); endproperty
    a_init_mode: assert property (p_init_mode) else $error("mode pins moved");
    property p_no_rd_empty; $fell(rd_n) |-> $past(emp_ok) ##0 s_pulse(rd_n); endproperty
    a_no_rd_empty: assert property (p_no_rd_empty) else $error("read while empty");
    property p_no_wr_full; $fell(wr_n) |-> ful_ok ##0 s_pulse(wr_n); endproperty
    a_no_wr_full: assert property (p_no_wr_full) else $error("write while full");
endmodule : afrc_properties

bind afrc_host afrc_properties u_props (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .fifo_pins(fifo_pins), .fifo_flags(fifo_flags));

// ---- afrc_fifo_model.sv ----
// Behavioural model of the strobe-timed FIFO devices behind the controller.
`timescale 1ns/100ps
module afrc_fifo_model import afrc_pkg::*; (
    // Pins from the controller
    input wire afrc_pins_s pins,
    // Flags and data back
    output wire afrc_flags_s flags
);
    logic [8:0] mem [4096];
    logic [11:0] wp;
    logic [11:0] rp;
    logic [12:0] n;
    logic [8:0] q;
    logic cas;
    always @(negedge pins.init_strobe_n) begin
        wp = '0;
        rp = '0;
        n = '0;
    end
    always @(posedge pins.init_strobe_n) cas = pins.chain_token_in_n;
    always @(posedge pins.write_strobe_n) begin
        if (n < 13'h1000) begin
            mem[wp] = pins.write_word_in;
            wp = wp + 12'h001;
            n = n + 13'h0001;
        end
    end
    always @(negedge pins.read_strobe_n) begin
        if (n != 13'h0000) begin
            q = mem[rp];
            rp = rp + 12'h001;
            n = n - 13'h0001;
        end
    end
    always @(negedge pins.first_load_or_rewind_n) begin
        if (!cas && pins.init_strobe_n) begin
            rp = '0;
            n = {1'b0, wp};
        end
    end
    assign flags.empty_flag_n = {NDEV{n != 13'h0000}};
    assign flags.full_flag_n = {NDEV{n != 13'h1000}};
    assign flags.chain_out_or_half_flag = cas | (n <= 13'h0800);
    // Released data lines show the inverse of the last word.
    assign flags.read_word_out = pins.read_strobe_n ? ~q : q;
endmodule : afrc_fifo_model

// ---- afrc_host_tb.sv ----
// Self-checking testbench of the FIFO host controller.
`timescale 1ns/100ps
module afrc_host_tb import afrc_pkg::*;;
    logic clk = 0;
    logic rst_b = 0;
    logic [4:0] avs_address = '0;
    logic avs_read = 0;
    logic avs_write = 0;
    logic [31:0] avs_writedata = '0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    afrc_pins_s fifo_pins;
    afrc_flags_s fifo_flags;
    int bad_count = 0;
    int total_checks = 0;
    int seed = 32'h8d9d;
    logic [31:0] r;
    logic [8:0] wq [$];
    always #5 clk = ~clk;
    afrc_host DUT (.clk(clk), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .fifo_pins(fifo_pins), .fifo_flags(fifo_flags));
    afrc_fifo_model u_dev (.pins(fifo_pins), .flags(fifo_flags));
    task automatic results;
        $display("Mismatches %0d of %0d checks", bad_count, total_checks);
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR t=%0t got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        int k;
        k = 0;
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= !w;
        do begin
            @(posedge clk);
            k++;
        end while (avs_waitrequest !== 1'b0 && k < 300);
        r = avs_readdata;
        avs_write <= 0;
        avs_read <= 0;
        @(posedge clk);
        if (k >= 300) begin
            chk(k, 0);
            results();
        end
    endtask : bus
    // Polls the busy bit until the sequencer is idle.
    task automatic cmd(input logic [3:0] c);
        int k;
        k = 0;
        if (c != 4'h0) bus(1, REG_CMD, {28'h0, c});
        do begin
            bus(0, REG_STATUS, 0);
            k++;
        end while (r[ST_BUSY] !== 1'b0 && k < 100);
        if (k >= 100) begin
            chk(k, 0);
            results();
        end
    endtask : cmd
    task automatic put(input logic [8:0] d);
        bus(1, REG_WDATA, {23'h0, d});
        bus(1, REG_CMD, 32'h2);
        wq.push_back(d);
    endtask : put
    task automatic get(input logic [8:0] e);
        cmd(4'h4);
        bus(0, REG_RDATA, 0);
        chk(r, {23'h0, e});
    endtask : get
    function automatic logic [31:0] st_exp(input int n, input logic cas, input logic rf);
        return {26'h0, rf, cas, cas | (n <= 2048), n != 4096, n != 0, 1'b0};
    endfunction : st_exp
    task automatic st(input int n, input logic cas, input logic rf);
        cmd(4'h0);
        chk(r & 32'h3f, st_exp(n, cas, rf));
    endtask : st
    initial begin
        repeat (8) @(posedge clk);
        rst_b <= 1;
        @(posedge clk);
        bus(0, 5'h1c, 0);
        chk(r, 0);
        cmd(4'h1);
        st(0, 0, 0);
        cmd(4'h4);
        st(0, 0, 1);
        bus(1, REG_STATUS, 32'h20);
        for (int i = 0; i < 6; i++) put(9'($random(seed)));
        st(6, 0, 0);
        for (int i = 0; i < 3; i++) get(wq[i]);
        for (int j = 0; j < 2; j++) begin
            cmd(4'h8);
            st(6, 0, 0);
            chk({31'h0, r[ST_REWOUND]}, 32'h1);
            for (int i = 0; i < 6; i++) get(wq[i]);
        end
        bus(1, REG_CTRL, 32'h1);
        cmd(4'h1);
        cmd(4'h8);
        st(0, 1, 1);
        bus(1, REG_CTRL, 32'h0);
        bus(1, REG_STATUS, 32'h20);
        cmd(4'h1);
        wq.delete();
        for (int c = 1; c <= 4096; c++) begin
            put(9'($random(seed)));
            if (c == 2048 || c == 2049) st(c, 0, 0);
        end
        st(4096, 0, 0);
        cmd(4'h2);
        st(4096, 0, 1);
        bus(0, REG_COUNT, 0);
        chk(r, 32'h1000);
        get(wq[0]);
        bus(1, REG_STATUS, 32'h20);
        st(4095, 0, 0);
        cmd(4'h8);
        cmd(4'h2);
        st(0, 0, 1);
        bus(1, REG_CTRL, 32'h3);
        cmd(4'h1);
        bus(1, REG_CTRL, 32'h0);
        put(9'h0a5);
        st(1, 1, 1);
        chk({31'h0, r[ST_REWOUND]}, 32'h0);
        chk({30'h0, fifo_pins.chain_token_in_n, fifo_pins.first_load_or_rewind_n}, 32'h2);
        get(9'h0a5);
        results();
    end
endmodule : afrc_host_tb
